//--- rtl/dadp_consts.svh
/*
 * Constants of the dual converter data port: word width, register offsets,
 * status bit positions and reset values.
 * Assumes inclusion by bare name from the package and the core module.
 */
`ifndef DADP_CONSTS_SVH
`define DADP_CONSTS_SVH

`define DADP_WORD_W 14
`define DADP_WORD_MSB 13
`define DADP_ADDR_W 8
`define DADP_REG_CTRL 8'h00
`define DADP_REG_STATUS 8'h04
`define DADP_REG_DAC 8'h08
`define DADP_REG_ADC 8'h0c
`define DADP_CTRL_MUX 0
`define DADP_ST_MODE 1'b0
`define DADP_ST_MODE_BIT 0
`define DADP_ST_PDOWN_BIT 1
`define DADP_ST_RANGE_A_BIT 2
`define DADP_ST_RANGE_B_BIT 3
`define DADP_ST_PHASE_BIT 4
`define DADP_HI_LSB 16
`define DADP_MUX_RESET 1'b0
`define DADP_WORD_RESET 14'h0000
`define DADP_DATA_RESET 32'h0000_0000
`define DADP_RESP_OKAY 2'b00
`define DADP_RESP_SLVERR 2'b10
`define DADP_MODE_DUAL 1'b1

`endif

//--- rtl/dadp_pkg.sv
/*
 * Types of the dual converter data port: interleave phase, front-end
 * carrier and the core's whole state.
 * Assumes dadp_consts.svh on the include path.
 */
`include "dadp_consts.svh"

package dadp_pkg;

    typedef enum logic {DADP_PH_I, DADP_PH_Q} dadp_phase_e;

    typedef logic [`DADP_WORD_W-1:0] dadp_word_t;

    typedef struct packed {
        logic over;
        dadp_word_t word;
    } dadp_adc_in_s;

    typedef struct packed {
        dadp_word_t dac_out_a;
        dadp_word_t dac_out_b;
        dadp_word_t i_latch;
        dadp_phase_e phase;
        logic mode_q;
        logic strobe_a_q;
        logic strobe_b_q;
        logic clk_a_q;
        logic clk_b_q;
        dadp_word_t adc_word_a;
        dadp_word_t adc_word_b;
        logic flag_a;
        logic flag_b;
        logic mux_en;
        logic sticky_a;
        logic sticky_b;
        logic aw_held;
        logic w_held;
        logic [`DADP_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dadp_state_s;

endpackage

//--- rtl/dadp_core.sv
/*
 * Digital side of a dual 14-bit ADC and dual 14-bit DAC with an AXI4-Lite
 * register slave: DAC dual-port and interleaved capture, ADC independent
 * and multiplexed output, range flags, output enables and power-down.
 * Assumes all pins synchronous to aclk; converter clocks and write strobes
 * are sampled and edge detected, so each must stay high and low at least
 * one aclk period.
 */
// Notes on behaviour
// - DAC takes 14-bit words, bounded rate
// - Dual-port mode: channels independent
// - Interleaved: alternate words into I, Q latches
// - Interleaved: both outputs refresh at half rate
// - ADC gives 14-bit words, bounded rate
// - No mux: ADC channels independent
// - Mux: both channels on bus A, double rate
// - Per-channel out-of-range flag beside word
// - Bus bits 0 to 13, bit 13 MSB
`timescale 1ns/100ps
`default_nettype none
`include "dadp_consts.svh"

module dadp_core
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`DADP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`DADP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`DADP_WORD_MSB:0] dac_word_a,
    input wire logic [`DADP_WORD_MSB:0] dac_word_b,
    input wire logic dac_write_strobe_a,
    input wire logic dac_write_strobe_b,
    input wire logic dac_mode_select,
    output logic [`DADP_WORD_MSB:0] dac_level_a,
    output logic [`DADP_WORD_MSB:0] dac_level_b,
    input wire dadp_pkg::dadp_adc_in_s adc_front_a,
    input wire dadp_pkg::dadp_adc_in_s adc_front_b,
    input wire logic adc_clock_in_a,
    input wire logic adc_clock_in_b,
    input wire logic adc_drive_enable_a,
    input wire logic adc_drive_enable_b,
    input wire logic adc_power_down,
    output logic [`DADP_WORD_MSB:0] adc_word_a,
    output logic [`DADP_WORD_MSB:0] adc_word_b,
    output logic adc_word_a_oe_n,
    output logic adc_word_b_oe_n,
    output logic adc_range_flag_a,
    output logic adc_range_flag_b
);

    dadp_pkg::dadp_state_s st_r;
    dadp_pkg::dadp_state_s st_nxt;
    logic rise_sa;
    logic rise_sb;
    logic rise_ca;
    logic fall_ca;
    logic rise_cb;

    function automatic logic rose(input logic prev, input logic cur);
        rose = cur & ~prev;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    // One sample per strobe or clock edge caps the rate at half of aclk
    assign rise_sa = rose(st_r.strobe_a_q, dac_write_strobe_a);
    assign rise_sb = rose(st_r.strobe_b_q, dac_write_strobe_b);
    assign rise_ca = rose(st_r.clk_a_q, adc_clock_in_a);
    assign fall_ca = rose(adc_clock_in_a, st_r.clk_a_q);
    assign rise_cb = rose(st_r.clk_b_q, adc_clock_in_b);

    assign s_axi_awready = ~st_r.aw_held & ~st_r.bvalid;
    assign s_axi_wready = ~st_r.w_held & ~st_r.bvalid;
    assign s_axi_arready = ~st_r.rvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign dac_level_a = st_r.dac_out_a;
    assign dac_level_b = st_r.dac_out_b;
    assign adc_word_a = st_r.adc_word_a;
    assign adc_word_b = st_r.adc_word_b;
    assign adc_range_flag_a = st_r.flag_a;
    assign adc_range_flag_b = st_r.flag_b;
    // Enables act at once so the host can turn the bus round in one cycle
    assign adc_word_a_oe_n = ~adc_drive_enable_a;
    assign adc_word_b_oe_n = ~adc_drive_enable_b;

    always_comb
    begin
        logic [31:0] status;
        logic [31:0] wr;
        status = `DADP_DATA_RESET;
        wr = `DADP_DATA_RESET;
        st_nxt = st_r;
        st_nxt.strobe_a_q = dac_write_strobe_a;
        st_nxt.strobe_b_q = dac_write_strobe_b;
        st_nxt.clk_a_q = adc_clock_in_a;
        st_nxt.clk_b_q = adc_clock_in_b;
        st_nxt.mode_q = dac_mode_select;
        if (st_r.mode_q != dac_mode_select)
        begin
            st_nxt.phase = dadp_pkg::DADP_PH_I;
        end
        else if (dac_mode_select == `DADP_MODE_DUAL)
        begin
            if (rise_sa)
            begin
                st_nxt.dac_out_a = dac_word_a;
            end
            if (rise_sb)
            begin
                st_nxt.dac_out_b = dac_word_b;
            end
        end
        else if (rise_sa)
        begin
            unique case (st_r.phase)
                dadp_pkg::DADP_PH_I:
                begin
                    st_nxt.i_latch = dac_word_a;
                    st_nxt.phase = dadp_pkg::DADP_PH_Q;
                end
                dadp_pkg::DADP_PH_Q:
                begin
                    st_nxt.dac_out_a = st_r.i_latch;
                    st_nxt.dac_out_b = dac_word_a;
                    st_nxt.phase = dadp_pkg::DADP_PH_I;
                end
            endcase
        end
        if (adc_power_down)
        begin
            st_nxt.adc_word_a = `DADP_WORD_RESET;
            st_nxt.adc_word_b = `DADP_WORD_RESET;
            st_nxt.flag_a = 1'b0;
            st_nxt.flag_b = 1'b0;
        end
        else
        begin
            if (rise_ca)
            begin
                st_nxt.adc_word_a = adc_front_a.word;
                st_nxt.flag_a = adc_front_a.over;
            end
            else if (fall_ca && st_r.mux_en)
            begin
                st_nxt.adc_word_a = adc_front_b.word;
                st_nxt.flag_a = adc_front_b.over;
            end
            if (rise_cb)
            begin
                st_nxt.adc_word_b = adc_front_b.word;
                st_nxt.flag_b = adc_front_b.over;
            end
        end
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_held && st_r.w_held)
        begin
            wr = merge(`DADP_DATA_RESET, st_r.wdata, st_r.wstrb);
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `DADP_RESP_OKAY;
            unique case (st_r.awaddr)
                `DADP_REG_CTRL:
                begin
                    st_nxt.mux_en = wr[`DADP_CTRL_MUX];
                end
                `DADP_REG_STATUS:
                begin
                    if (wr[`DADP_ST_RANGE_A_BIT])
                    begin
                        st_nxt.sticky_a = 1'b0;
                    end
                    if (wr[`DADP_ST_RANGE_B_BIT])
                    begin
                        st_nxt.sticky_b = 1'b0;
                    end
                end
                `DADP_REG_DAC, `DADP_REG_ADC:
                begin
                    st_nxt.bresp = `DADP_RESP_OKAY;
                end
                default:
                begin
                    st_nxt.bresp = `DADP_RESP_SLVERR;
                end
            endcase
        end
        // Placed after the clear so a range event in the clearing cycle survives
        if (!adc_power_down && rise_ca && adc_front_a.over)
        begin
            st_nxt.sticky_a = 1'b1;
        end
        if (!adc_power_down && (rise_cb || (fall_ca && st_r.mux_en)) && adc_front_b.over)
        begin
            st_nxt.sticky_b = 1'b1;
        end
        status[`DADP_ST_MODE_BIT] = st_r.mode_q;
        status[`DADP_ST_PDOWN_BIT] = adc_power_down;
        status[`DADP_ST_RANGE_A_BIT] = st_r.sticky_a;
        status[`DADP_ST_RANGE_B_BIT] = st_r.sticky_b;
        status[`DADP_ST_PHASE_BIT] = (st_r.phase == dadp_pkg::DADP_PH_Q);
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `DADP_RESP_OKAY;
            st_nxt.rdata = `DADP_DATA_RESET;
            unique case (s_axi_araddr)
                `DADP_REG_CTRL:
                begin
                    st_nxt.rdata[`DADP_CTRL_MUX] = st_r.mux_en;
                end
                `DADP_REG_STATUS:
                begin
                    st_nxt.rdata = status;
                end
                `DADP_REG_DAC:
                begin
                    st_nxt.rdata[`DADP_WORD_MSB:0] = st_r.dac_out_a;
                    st_nxt.rdata[`DADP_HI_LSB +: `DADP_WORD_W] = st_r.dac_out_b;
                end
                `DADP_REG_ADC:
                begin
                    st_nxt.rdata[`DADP_WORD_MSB:0] = st_r.adc_word_a;
                    st_nxt.rdata[`DADP_HI_LSB +: `DADP_WORD_W] = st_r.adc_word_b;
                end
                default:
                begin
                    st_nxt.rresp = `DADP_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.mux_en <= `DADP_MUX_RESET;
            st_r.mode_q <= `DADP_ST_MODE;
            st_r.phase <= dadp_pkg::DADP_PH_I;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_DUAL_A: assert property ((st_r.mode_q && dac_mode_select && rise_sa) |=>
        dac_level_a == $past(dac_word_a)) else $error("dual port word A not taken");
    AST_DUAL_B_HOLD: assert property ((st_r.mode_q && dac_mode_select && !rise_sb) |=>
        $stable(dac_level_b)) else $error("dual port B moved without strobe");
    AST_ILV_FIRST: assert property ((!st_r.mode_q && !dac_mode_select && rise_sa
        && st_r.phase == dadp_pkg::DADP_PH_I) |=> $stable(dac_level_a) && $stable(dac_level_b)
        && st_r.phase == dadp_pkg::DADP_PH_Q) else $error("I word refreshed outputs");
    AST_ILV_PAIR: assert property ((!st_r.mode_q && !dac_mode_select && rise_sa
        && st_r.phase == dadp_pkg::DADP_PH_Q) |=> dac_level_a == $past(st_r.i_latch)
        && dac_level_b == $past(dac_word_a)) else $error("I and Q pair not converted");
    AST_ADC_B: assert property ((!adc_power_down && rise_cb) |=>
        adc_word_b == $past(adc_front_b.word)) else $error("channel B sample lost");
    AST_MUX_B_ON_A: assert property ((!adc_power_down && st_r.mux_en && fall_ca) |=>
        adc_word_a == $past(adc_front_b.word)) else $error("mux B sample missing on bus A");
    AST_RANGE_A: assert property ((!adc_power_down && rise_ca) |=>
        adc_range_flag_a == $past(adc_front_a.over)) else $error("range flag A wrong");
    AST_MSB_A: assert property ((!adc_power_down && rise_ca) |=>
        adc_word_a[`DADP_WORD_MSB] == $past(adc_front_a.word[`DADP_WORD_MSB]))
        else $error("bit 13 not the sample MSB");
    AST_PDOWN: assert property (adc_power_down [*2] |->
        adc_word_a == '0 && adc_word_b == '0) else $error("power down left words");
    AST_BRESP: assert property ((st_r.aw_held && st_r.w_held) |=> s_axi_bvalid)
        else $error("write response late");

    COV_DUAL: cover property (st_r.mode_q && rise_sa ##1 rise_sb);
    COV_ILV: cover property (!st_r.mode_q && rise_sa ##[1:20] rise_sa);
    COV_MUX: cover property (st_r.mux_en && rise_ca ##[1:20] fall_ca);
    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);

endmodule
`default_nettype wire

//--- bench/dadp_host_model.sv
/* Host logic model: converter clocks, DAC words and strobes, ADC controls.
   Assumes the bench calls one task at a time, all timed on aclk. */
`timescale 1ns/100ps
`default_nettype none
module dadp_host_model
(
    input wire logic aclk,
    output dadp_pkg::dadp_word_t dac_word_a,
    output dadp_pkg::dadp_word_t dac_word_b,
    output logic dac_write_strobe_a,
    output logic dac_write_strobe_b,
    output logic dac_mode_select,
    output logic adc_clock_in_a,
    output logic adc_clock_in_b,
    output logic adc_drive_enable_a,
    output logic adc_drive_enable_b,
    output logic adc_power_down
);
    initial
    begin
        {dac_word_a, dac_word_b, dac_write_strobe_a, dac_write_strobe_b} = '0;
        {adc_clock_in_a, adc_clock_in_b, adc_power_down} = 3'b000;
        {dac_mode_select, adc_drive_enable_a, adc_drive_enable_b} = 3'b111;
    end

    // Word valid only while its strobe is high, inverted afterwards
    task automatic dac_put(input logic ch, input dadp_pkg::dadp_word_t w);
        @(posedge aclk);
        dac_word_a <= ch ? dac_word_a : w;
        dac_word_b <= ch ? w : dac_word_b;
        dac_write_strobe_a <= !ch;
        dac_write_strobe_b <= ch;
        @(posedge aclk);
        dac_write_strobe_a <= 1'b0;
        dac_write_strobe_b <= 1'b0;
        dac_word_a <= ~dac_word_a;
        dac_word_b <= ~dac_word_b;
        repeat (2) @(posedge aclk);
    endtask

    // Mask 2'b11 gives both channels one common clock
    task automatic adc_clk(input logic [1:0] m, input logic lvl);
        @(posedge aclk);
        if (m[0])
            adc_clock_in_a <= lvl;
        if (m[1])
            adc_clock_in_b <= lvl;
        repeat (3) @(posedge aclk);
    endtask

    task automatic set_ctl(input logic mode, input logic [1:0] en, input logic pd);
        @(posedge aclk);
        dac_mode_select <= mode;
        {adc_drive_enable_a, adc_drive_enable_b} <= en;
        adc_power_down <= pd;
        repeat (2) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

//--- bench/tb_dual_adc_dac_data_port.sv
/* Bench of the dual converter data port: AXI4-Lite master, host model,
   front-end stimulus and a response scoreboard.
   Assumes the core's chosen register map and capture latencies. */
`timescale 1ns/100ps
`default_nettype none
module tb_dual_adc_dac_data_port;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    dadp_pkg::dadp_word_t dac_word_a, dac_word_b, dac_level_a, dac_level_b, adc_word_a, adc_word_b;
    logic dac_write_strobe_a, dac_write_strobe_b, dac_mode_select, adc_clock_in_a, adc_clock_in_b;
    logic adc_drive_enable_a, adc_drive_enable_b, adc_power_down, adc_word_a_oe_n, adc_word_b_oe_n;
    logic adc_range_flag_a, adc_range_flag_b;
    dadp_pkg::dadp_adc_in_s adc_front_a, adc_front_b;
    logic [33:0] exp_q[$];
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h1b7d69ae;
    dadp_pkg::dadp_word_t wa, wb;

    dadp_core u_dadp_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dac_word_a, .dac_word_b,
        .dac_write_strobe_a, .dac_write_strobe_b, .dac_mode_select, .dac_level_a, .dac_level_b,
        .adc_front_a, .adc_front_b, .adc_clock_in_a, .adc_clock_in_b, .adc_drive_enable_a,
        .adc_drive_enable_b, .adc_power_down, .adc_word_a, .adc_word_b, .adc_word_a_oe_n,
        .adc_word_b_oe_n, .adc_range_flag_a, .adc_range_flag_b);

    dadp_host_model u_dadp_host_model (.aclk, .dac_word_a, .dac_word_b, .dac_write_strobe_a,
        .dac_write_strobe_b, .dac_mode_select, .adc_clock_in_a, .adc_clock_in_b,
        .adc_drive_enable_a, .adc_drive_enable_b, .adc_power_down);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Responses land in issue order, one transfer at a time
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            miscompares++;
            final_report();
        end
        if (s_axi_bvalid && s_axi_bready)
            chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end

    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {adc_front_a, adc_front_b} = '0;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h00, 34'h0);
        axi_write(8'h10, 32'h1, 2'b10);
        axi_read(8'h10, {2'b10, 32'h0});
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            wa = seed[13:0];
            wb = seed[29:16];
            u_dadp_host_model.dac_put(1'b0, wa);
            #1 chk(34'(dac_level_a), 34'(wa));
            u_dadp_host_model.dac_put(1'b1, wb);
            #1 chk(34'({dac_level_a, dac_level_b}), 34'({wa, wb}));
        end
        axi_write(8'h08, 32'hffffffff, 2'b00);
        axi_read(8'h08, {4'h0, wb, 2'h0, wa});
        u_dadp_host_model.set_ctl(1'b0, 2'b11, 1'b0);
        seed = lfsr(seed);
        u_dadp_host_model.dac_put(1'b0, seed[13:0]);
        #1 chk(34'({dac_level_a, dac_level_b}), 34'({wa, wb}));
        u_dadp_host_model.dac_put(1'b1, seed[29:16]);
        #1 chk(34'({dac_level_a, dac_level_b}), 34'({wa, wb}));
        u_dadp_host_model.dac_put(1'b0, seed[29:16]);
        #1 chk(34'({dac_level_a, dac_level_b}), 34'({seed[13:0], seed[29:16]}));
        axi_read(8'h04, 34'h0);
        u_dadp_host_model.set_ctl(1'b1, 2'b10, 1'b0);
        // Channel A enabled drives, so its active-low enable reads zero
        #1 chk(34'({adc_word_a_oe_n, adc_word_b_oe_n}), 34'h1);
        @(posedge aclk);
        seed = lfsr(seed);
        adc_front_a <= {1'b1, seed[13:0]};
        adc_front_b <= {1'b1, seed[29:16]};
        u_dadp_host_model.adc_clk(2'b11, 1'b1);
        #1 chk(34'({adc_range_flag_a, adc_word_a, adc_range_flag_b, adc_word_b}),
            34'({adc_front_a, adc_front_b}));
        u_dadp_host_model.adc_clk(2'b11, 1'b0);
        axi_read(8'h04, 34'hd);
        axi_write(8'h04, 32'hc, 2'b00);
        axi_read(8'h04, 34'h1);
        axi_write(8'h00, 32'h1, 2'b00);
        @(posedge aclk);
        seed = lfsr(seed);
        adc_front_a <= {1'b0, seed[13:0]};
        adc_front_b <= {1'b0, seed[29:16]};
        u_dadp_host_model.adc_clk(2'b11, 1'b1);
        #1 chk(34'({adc_word_a, adc_word_b}), 34'({seed[13:0], seed[29:16]}));
        u_dadp_host_model.adc_clk(2'b11, 1'b0);
        #1 chk(34'(adc_word_a), 34'(seed[29:16]));
        axi_write(8'h00, 32'h0, 2'b00);
        u_dadp_host_model.set_ctl(1'b1, 2'b11, 1'b1);
        u_dadp_host_model.adc_clk(2'b11, 1'b1);
        #1 chk(34'({adc_range_flag_a, adc_word_a, adc_range_flag_b, adc_word_b}),
            34'h0);
        axi_read(8'h04, 34'h3);
        final_report();
    end
endmodule
`default_nettype wire
